// ==== pkg/apcs_pkg.sv ====
/*
 * Shared constants and types for the converter power and calibration sequencer:
 * register offsets, field positions, reset values, state codes and delay counts.
 * Assumes a single clock domain and an SPI register port on the device pins.
 */
// What this block does
// - Power-down exit runs automatic core calibration.
// - Sleep exit never starts a calibration.
// - Mode changes leave configuration registers untouched.
// - Power-up: wait 8.4e6 samples, then calibrate.
// - Primary calibration lasts about 1.0e6 samples.
// - Calibration-done bit at 0x6c; host waits for it.
// - After secondary calibration, link initialization starts itself.
// - Power-down exit: wait 262e3, calibrate 1e6 samples.
// - Two's complement default, offset binary optional.
// - Subclass 1 deterministic latency, subclass 0 mostly.
// - One or two lanes, K value, optional scrambling.
// - Frame octets and density follow lane count; one sample per frame.
// - Offer D21.5, K28.5, ILA, PRBS, ramp; no RPAT/JSPAT.
// - No idle mode, transport tests or polarity inversion.
// - Accept periodic, pulsed or one-shot SYSREF.
// - Divider change re-initializes the serial link, except one made during sleep.
package apcs_pkg;

   // ****************************************************************
   // Register map (byte addresses on the SPI port).
   // ****************************************************************
   localparam logic [14:0] ADDR_POWER_MODE = 15'h0002;
   localparam logic [14:0] ADDR_CLOCK_DIVIDER = 15'h0013;
   localparam logic [14:0] ADDR_CAL_SETUP_A = 15'h0016;
   localparam logic [14:0] ADDR_CAL_SETUP_B = 15'h001e;
   localparam logic [14:0] ADDR_CAL_SETUP_C = 15'h0028;
   localparam logic [14:0] ADDR_LINK_FORMAT = 15'h0060;
   localparam logic [14:0] ADDR_LINK_FRAMES = 15'h0061;
   localparam logic [14:0] ADDR_LINK_STATUS = 15'h006c;

   // ****************************************************************
   // Reset values and field positions.
   // ****************************************************************
   localparam logic [7:0] RST_POWER_MODE = 8'h00;
   localparam logic [7:0] RST_CLOCK_DIVIDER = 8'h00;
   localparam logic [7:0] RST_CAL_SETUP = 8'h00;
   localparam logic [7:0] RST_LINK_FORMAT = 8'h08;
   localparam logic [7:0] RST_LINK_FRAMES = 8'h1f;
   localparam int FMT_OFFSET_BIN = 0;
   localparam int FMT_TWO_LANES = 1;
   localparam int FMT_SCRAMBLE = 2;
   localparam int FMT_SUBCLASS1 = 3;
   localparam int FMT_TEST_LSB = 4;
   localparam int STAT_CAL_DONE = 0;
   localparam int STAT_CAL_BUSY = 1;
   localparam int STAT_POWER_DOWN = 2;
   localparam int STAT_SLEEP = 3;

   // Power mode field codes in the low two bits; 2'b11 also means power-down.
   localparam logic [1:0] PM_NORMAL = 2'h0;
   localparam logic [1:0] PM_SLEEP = 2'h1;

   // Smallest frames-per-multiframe for one and two lanes.
   localparam logic [5:0] K_MIN_ONE_LANE = 6'h09;
   localparam logic [5:0] K_MIN_TWO_LANES = 6'h11;

   // ****************************************************************
   // Delays, in sampling clock cycles (one sample tick each).
   // ****************************************************************
   localparam logic [23:0] PWRUP_DELAY_SAMPLES = 24'd8400000;
   localparam logic [23:0] CAL_SAMPLES = 24'd1000000;
   localparam logic [23:0] PD_EXIT_SAMPLES = 24'd262000;
   localparam int SPI_FRAME_BITS = 24;
   localparam logic [4:0] SPI_LAST_BIT = 5'(SPI_FRAME_BITS - 1);
   localparam logic [4:0] SPI_ADDR_DONE = 5'd15;

   typedef enum logic [2:0] {
      ST_WAIT_SUPPLY = 3'b000,
      ST_PWRUP_DELAY = 3'b001,
      ST_CALIBRATE = 3'b010,
      ST_RUN = 3'b011,
      ST_POWER_DOWN = 3'b100,
      ST_SLEEP = 3'b101,
      ST_PD_EXIT = 3'b110
   } apcs_state_t;

   typedef enum logic [2:0] {
      TM_NORMAL = 3'b000,
      TM_D21_5 = 3'b001,
      TM_K28_5 = 3'b010,
      TM_ILA = 3'b011,
      TM_PRBS7 = 3'b100,
      TM_PRBS23 = 3'b101,
      TM_RAMP = 3'b110
   } apcs_test_mode_t;

   typedef struct packed {
      logic [15:0] chan_a;
      logic [15:0] chan_b;
   } apcs_sample_pair_t;

   typedef struct packed {
      logic two_lanes;
      logic [1:0] octets_per_frame;
      logic [1:0] samples_per_frame;
      logic high_density;
      logic [5:0] frames_per_multiframe;
      logic scramble;
      logic subclass1;
      apcs_test_mode_t test_mode;
   } apcs_link_cfg_t;

endpackage : apcs_pkg

// ==== rtl/apcs_timer.sv ====
/*
 * Loadable down-counter that counts sample ticks and pulses when a delay ends.
 * Assumes the load value is at least one and that tick is a one-cycle strobe.
 */
`timescale 1ns/1ps
module apcs_timer (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic load_in,
   input wire logic [23:0] count_in,
   input wire logic tick_in,
   output logic done_out
);
   import apcs_pkg::*;

   logic [23:0] remain;
   logic busy;

   // A fresh load overrides a countdown in progress, so a restarted phase never
   // inherits the tail of the previous one.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         remain <= 24'h000000;
         busy <= 1'b0;
         done_out <= 1'b0;
      end else if (load_in) begin
         remain <= count_in;
         busy <= 1'b1;
         done_out <= 1'b0;
      end else if (busy && tick_in) begin
         remain <= remain - 24'h000001;
         busy <= (remain != 24'h000001);
         done_out <= (remain == 24'h000001);
      end else begin
         done_out <= 1'b0;
      end
   end

endmodule : apcs_timer

// ==== rtl/apcs_top.sv ====
/*
 * Power-state and calibration sequencer for a dual-channel converter with a serial
 * link: SPI register file, power-up and power-down-exit calibration timing, sample
 * clock divider, output format, link configuration and multiframe alignment.
 * Assumes all pins, SPI included, are synchronous to clk_in, the device clock input.
 */
`timescale 1ns/1ps
module apcs_top #(
   parameter logic [23:0] PWRUP_DELAY_CYC = apcs_pkg::PWRUP_DELAY_SAMPLES,
   parameter logic [23:0] CAL_CYC = apcs_pkg::CAL_SAMPLES,
   parameter logic [23:0] PD_EXIT_CYC = apcs_pkg::PD_EXIT_SAMPLES
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic supply_ok_in,
   input wire logic sysref_in,
   input wire logic spi_sclk_in,
   input wire logic spi_cs_n_in,
   input wire logic spi_sdi_in,
   input wire apcs_pkg::apcs_sample_pair_t samples_in,
   output logic spi_sdo_out,
   output logic spi_sdo_oe_out,
   output logic cal_done_out,
   output logic power_down_out,
   output logic sleep_out,
   output logic link_reinit_out,
   output logic lmfc_out,
   output apcs_pkg::apcs_sample_pair_t samples_out,
   output apcs_pkg::apcs_link_cfg_t link_cfg_out
);
   import apcs_pkg::*;

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   logic [7:0] power_mode_control, input_clock_divider, link_format, link_frames, link_status;
   logic [7:0] calibration_setup_a, calibration_setup_b, calibration_setup_c, sdo_shift, wr_data;
   logic sclk_prev, sclk_rise, sclk_fall, read_active, wr_now, rd_now, div_changed, sample_tick;
   logic sysref_prev, sysref_rise, timer_load, timer_done, next_cal_done;
   logic [4:0] bit_cnt;
   logic [22:0] shift_in;
   logic [14:0] wr_addr, rd_addr;
   logic [2:0] div_cnt, div_last;
   apcs_state_t state, next_state;
   logic [23:0] timer_count;
   logic [5:0] k_value, frame_cnt;
   apcs_test_mode_t test_mode;

   // ****************************************************************
   // SPI slave: 24-bit frames, read flag, 15-bit address, 8-bit data.
   // ****************************************************************
   // Edges are only seen while the port is selected, so a stray clock with the
   // select high cannot shift in bits.
   assign sclk_rise = spi_sclk_in && !sclk_prev && !spi_cs_n_in;
   assign sclk_fall = !spi_sclk_in && sclk_prev && !spi_cs_n_in;
   assign wr_now = sclk_rise && (bit_cnt == SPI_LAST_BIT) && !shift_in[22];
   assign wr_addr = shift_in[21:7];
   assign wr_data = {shift_in[6:0], spi_sdi_in};
   assign rd_now = sclk_rise && (bit_cnt == SPI_ADDR_DONE) && shift_in[14];
   assign rd_addr = {shift_in[13:0], spi_sdi_in};

   // Bit counter and input shifter.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sclk_prev <= 1'b0;
         bit_cnt <= 5'h00;
         shift_in <= 23'h000000;
      end else begin
         sclk_prev <= spi_sclk_in;
         if (spi_cs_n_in) begin
            bit_cnt <= 5'h00;
         end else if (sclk_rise) begin
            shift_in <= {shift_in[21:0], spi_sdi_in};
            bit_cnt <= (bit_cnt == SPI_LAST_BIT) ? 5'h00 : bit_cnt + 5'h01;
         end
      end
   end

   // Read data is captured when the address completes and shifted out on falling
   // edges, so the host samples each bit on the following rising edge.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sdo_shift <= 8'h00;
         read_active <= 1'b0;
         spi_sdo_out <= 1'b0;
         spi_sdo_oe_out <= 1'b0;
      end else if (spi_cs_n_in) begin
         read_active <= 1'b0;
         spi_sdo_oe_out <= 1'b0;
      end else if (rd_now) begin
         sdo_shift <= read_reg(rd_addr);
         read_active <= 1'b1;
      end else if (sclk_fall && read_active) begin
         spi_sdo_out <= sdo_shift[7];
         spi_sdo_oe_out <= 1'b1;
         sdo_shift <= {sdo_shift[6:0], 1'b0};
      end
   end

   // Read multiplexer; unmapped addresses read as zero.
   function automatic logic [7:0] read_reg(input logic [14:0] addr);
      logic [7:0] value;
      value = 8'h00;
      unique case (addr)
         ADDR_POWER_MODE: value = power_mode_control;
         ADDR_CLOCK_DIVIDER: value = input_clock_divider;
         ADDR_CAL_SETUP_A: value = calibration_setup_a;
         ADDR_CAL_SETUP_B: value = calibration_setup_b;
         ADDR_CAL_SETUP_C: value = calibration_setup_c;
         ADDR_LINK_FORMAT: value = link_format;
         ADDR_LINK_FRAMES: value = link_frames;
         ADDR_LINK_STATUS: value = link_status;
         default: value = 8'h00;
      endcase
      return value;
   endfunction : read_reg

   // ****************************************************************
   // Configuration registers.
   // ****************************************************************
   // Only host writes touch these; power-down and sleep never reset them, so the
   // setup survives every mode change.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         power_mode_control <= RST_POWER_MODE;
         input_clock_divider <= RST_CLOCK_DIVIDER;
         calibration_setup_a <= RST_CAL_SETUP;
         calibration_setup_b <= RST_CAL_SETUP;
         calibration_setup_c <= RST_CAL_SETUP;
         link_format <= RST_LINK_FORMAT;
         link_frames <= RST_LINK_FRAMES;
      end else if (wr_now) begin
         unique case (wr_addr)
            ADDR_POWER_MODE: power_mode_control <= wr_data;
            ADDR_CLOCK_DIVIDER: input_clock_divider <= wr_data;
            ADDR_CAL_SETUP_A: calibration_setup_a <= wr_data;
            ADDR_CAL_SETUP_B: calibration_setup_b <= wr_data;
            ADDR_CAL_SETUP_C: calibration_setup_c <= wr_data;
            ADDR_LINK_FORMAT: link_format <= wr_data;
            ADDR_LINK_FRAMES: link_frames <= wr_data;
            default: ;
         endcase
      end
   end

   // A divider write only counts as a change when the factor really differs.
   assign div_changed = wr_now && (wr_addr == ADDR_CLOCK_DIVIDER) && (wr_data[1:0] != input_clock_divider[1:0]);

   // ****************************************************************
   // Sample clock divider and SYSREF alignment.
   // ****************************************************************
   assign div_last = 3'((4'h1 << input_clock_divider[1:0]) - 4'h1);
   assign sysref_rise = sysref_in && !sysref_prev && link_format[FMT_SUBCLASS1];
   assign sample_tick = (div_cnt == div_last);

   // Any rising SYSREF edge realigns the sampling phase, whether the reference is
   // periodic, gapped or a single shot; subclass 0 ignores it.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sysref_prev <= 1'b0;
         div_cnt <= 3'h0;
      end else begin
         sysref_prev <= sysref_in;
         if (sysref_rise || sample_tick || div_cnt > div_last) begin
            div_cnt <= 3'h0;
         end else begin
            div_cnt <= div_cnt + 3'h1;
         end
      end
   end

   // ****************************************************************
   // Power and calibration sequencer.
   // ****************************************************************
   // Mode requests act only from run or the low-power states; one made during a timed phase waits for its end.
   always_comb begin
      next_state = state;
      unique case (state)
         ST_WAIT_SUPPLY: if (supply_ok_in) next_state = ST_PWRUP_DELAY;
         ST_PWRUP_DELAY: if (timer_done) next_state = ST_CALIBRATE;
         ST_CALIBRATE: if (timer_done) next_state = ST_RUN;
         ST_RUN: begin
            if (power_mode_control[1]) begin
               next_state = ST_POWER_DOWN;
            end else if (power_mode_control[1:0] == PM_SLEEP) begin
               next_state = ST_SLEEP;
            end
         end
         ST_POWER_DOWN: if (power_mode_control[1:0] == PM_NORMAL) next_state = ST_PD_EXIT;
         ST_PD_EXIT: if (timer_done) next_state = ST_CALIBRATE;
         ST_SLEEP: begin
            if (power_mode_control[1]) begin
               next_state = ST_POWER_DOWN;
            end else if (power_mode_control[1:0] == PM_NORMAL) begin
               next_state = ST_RUN;
            end
         end
         default: next_state = ST_WAIT_SUPPLY;
      endcase
   end

   // The timer is loaded on entry to each timed phase with that phase's length.
   always_comb begin
      timer_load = (next_state != state);
      timer_count = CAL_CYC;
      unique case (next_state)
         ST_PWRUP_DELAY: timer_count = PWRUP_DELAY_CYC;
         ST_PD_EXIT: timer_count = PD_EXIT_CYC;
         ST_CALIBRATE: timer_count = CAL_CYC;
         default: timer_load = 1'b0;
      endcase
   end

   // The done flag falls as soon as a calibration becomes pending and rises only
   // when the calibration phase ends; sleep keeps it.
   always_comb begin
      next_cal_done = cal_done_out;
      if (state == ST_CALIBRATE && timer_done) begin
         next_cal_done = 1'b1;
      end else if (next_state == ST_PWRUP_DELAY || next_state == ST_POWER_DOWN) begin
         next_cal_done = 1'b0;
      end
   end

   apcs_timer u_timer (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .load_in(timer_load),
      .count_in(timer_count),
      .tick_in(sample_tick),
      .done_out(timer_done)
   );

   // State register and the flags that mirror it.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state <= ST_WAIT_SUPPLY;
         cal_done_out <= 1'b0;
         power_down_out <= 1'b0;
         sleep_out <= 1'b0;
      end else begin
         state <= next_state;
         cal_done_out <= next_cal_done;
         power_down_out <= (next_state == ST_POWER_DOWN);
         sleep_out <= (next_state == ST_SLEEP);
      end
   end

   // Link start-up follows every calibration without host help; a divider change while running restarts it,
   // and changes made while powered down are covered by the calibration that follows.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         link_reinit_out <= 1'b0;
      end else begin
         link_reinit_out <= (state == ST_CALIBRATE && timer_done) || (state == ST_RUN && div_changed);
      end
   end

   // Status register image.
   assign link_status = {4'h0, sleep_out, power_down_out,
                         (state == ST_CALIBRATE || state == ST_PWRUP_DELAY || state == ST_PD_EXIT), cal_done_out};

   // ****************************************************************
   // Link configuration.
   // ****************************************************************
   // Unsupported pattern codes fall back to normal data, so no other test
   // sequence can ever be selected.
   always_comb begin
      unique case (link_format[FMT_TEST_LSB +: 3])
         3'b001: test_mode = TM_D21_5;
         3'b010: test_mode = TM_K28_5;
         3'b011: test_mode = TM_ILA;
         3'b100: test_mode = TM_PRBS7;
         3'b101: test_mode = TM_PRBS23;
         3'b110: test_mode = TM_RAMP;
         default: test_mode = TM_NORMAL;
      endcase
   end

   // K is clamped to the smallest legal value for the lane count.
   always_comb begin
      k_value = 6'({1'b0, link_frames[4:0]} + 6'h01);
      if (link_format[FMT_TWO_LANES] && k_value < K_MIN_TWO_LANES) begin
         k_value = K_MIN_TWO_LANES;
      end else if (!link_format[FMT_TWO_LANES] && k_value < K_MIN_ONE_LANE) begin
         k_value = K_MIN_ONE_LANE;
      end
   end

   // Frame layout follows the lane count alone; K, scrambling, subclass and test mode come from the registers.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         link_cfg_out <= '0;
      end else begin
         link_cfg_out.two_lanes <= link_format[FMT_TWO_LANES];
         link_cfg_out.octets_per_frame <= link_format[FMT_TWO_LANES] ? 2'h1 : 2'h2;
         link_cfg_out.samples_per_frame <= 2'h1;
         link_cfg_out.high_density <= link_format[FMT_TWO_LANES];
         link_cfg_out.frames_per_multiframe <= k_value;
         link_cfg_out.scramble <= link_format[FMT_SCRAMBLE];
         link_cfg_out.subclass1 <= link_format[FMT_SUBCLASS1];
         link_cfg_out.test_mode <= test_mode;
      end
   end

   // ****************************************************************
   // Multiframe clock and sample formatting.
   // ****************************************************************
   // One frame per sample; a SYSREF edge restarts the multiframe so the latency
   // is fixed in subclass 1.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         frame_cnt <= 6'h00;
         lmfc_out <= 1'b0;
      end else if (sysref_rise) begin
         frame_cnt <= 6'h00;
         lmfc_out <= 1'b1;
      end else if (sample_tick) begin
         frame_cnt <= (frame_cnt >= k_value - 6'h01) ? 6'h00 : frame_cnt + 6'h01;
         lmfc_out <= (frame_cnt >= k_value - 6'h01);
      end else begin
         lmfc_out <= 1'b0;
      end
   end

   // Offset binary is two's complement with the sign bit inverted, applied before framing; zero unless running.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         samples_out <= '0;
      end else if (state != ST_RUN) begin
         samples_out <= '0;
      end else if (sample_tick) begin
         samples_out.chan_a <= samples_in.chan_a ^ {link_format[FMT_OFFSET_BIN], 15'h0000};
         samples_out.chan_b <= samples_in.chan_b ^ {link_format[FMT_OFFSET_BIN], 15'h0000};
      end
   end

endmodule : apcs_top

// ==== sim/apcs_host_model.sv ====
/* Host model: sends 24-bit SPI frames, read flag first, MSB first.
   Assumes clk_in is the device clock and the pins are sampled on it. */
`timescale 1ns/1ps
module apcs_host_model (
   input wire logic clk_in,
   input wire logic sdo_in,
   output logic sclk_out,
   output logic cs_n_out,
   output logic sdi_out
);
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      sdi_out = 1'b0;
   end
   // A deselected data line toggles, so a stale bit can never be taken by luck.
   always @(posedge clk_in) begin
      if (cs_n_out) sdi_out <= ~sdi_out;
   end
   // Each clock phase lasts at least three clocks, above the two the pin sampler needs.
   task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [23:0] f;
      f = {rd, a, d};
      @(posedge clk_in) cs_n_out <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         @(posedge clk_in);
         sclk_out <= 1'b0;
         sdi_out <= f[i];
         repeat (4) @(posedge clk_in);
         if (i < 8) q[i] = sdo_in;
         sclk_out <= 1'b1;
         repeat (3) @(posedge clk_in);
      end
      sclk_out <= 1'b0;
      repeat (2) @(posedge clk_in);
      cs_n_out <= 1'b1;
      repeat (2) @(posedge clk_in);
   endtask : xfer
endmodule : apcs_host_model

// ==== sim/apcs_top_sva.sv ====
/* Checker on the sequencer pins, bound into apcs_top.
   Assumes one clk_in domain and the top module's delay parameters. */
`timescale 1ns/1ps
module apcs_top_sva #(
   parameter logic [23:0] PWRUP_DELAY_CYC = 24'd20,
   parameter logic [23:0] CAL_CYC = 24'd10
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic supply_ok_in,
   input wire logic spi_cs_n_in,
   input wire logic spi_sdo_oe_out,
   input wire logic cal_done_out,
   input wire logic power_down_out,
   input wire logic sleep_out,
   input wire logic link_reinit_out
);
   import apcs_pkg::*;
   logic [31:0] wait_cnt;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);
   // Cycles spent waiting for calibration; a pause or the done flag clears it.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         wait_cnt <= 32'h0;
      end else if (cal_done_out || power_down_out || !supply_ok_in) begin
         wait_cnt <= 32'h0;
      end else begin
         wait_cnt <= wait_cnt + 32'h1;
      end
   end
   // ******************************
   // Sequencing properties.
   // ******************************
   pd_not_done_a:
      assert property (power_down_out |-> !cal_done_out) else $error("done flag set in power-down");
   done_reinit_a:
      assert property ($rose(cal_done_out) |-> link_reinit_out) else $error("no link start at done");
   reinit_pulse_a:
      assert property (link_reinit_out |=> !link_reinit_out) else $error("link start pulse too long");
   reinit_run_a:
      assert property (link_reinit_out |-> cal_done_out && !power_down_out && !sleep_out)
         else $error("link start outside run");
   sleep_done_a:
      assert property (sleep_out |-> cal_done_out && !power_down_out) else $error("sleep lost done flag");
   done_fall_a:
      assert property ($fell(cal_done_out) |-> power_down_out) else $error("done flag cleared without power-down");
   cal_time_a:
      assert property ($rose(cal_done_out) |-> wait_cnt >= CAL_CYC) else $error("calibration too short");
   cal_bound_a:
      assert property (wait_cnt <= 8 * (int'(PWRUP_DELAY_CYC) + int'(CAL_CYC) + 2))
         else $error("calibration never ends");
   oe_release_a:
      assert property (spi_cs_n_in && $past(spi_cs_n_in) |-> !spi_sdo_oe_out) else $error("sdo driven unselected");
endmodule : apcs_top_sva
bind apcs_top apcs_top_sva #(.PWRUP_DELAY_CYC(PWRUP_DELAY_CYC), .CAL_CYC(CAL_CYC)) sva_u (.clk_in, .reset_in,
   .supply_ok_in, .spi_cs_n_in, .spi_sdo_oe_out, .cal_done_out, .power_down_out, .sleep_out, .link_reinit_out);

// ==== sim/apcs_top_bench.sv ====
/* Bench for apcs_top: power-up, secondary calibration, sleep and output format.
   Assumes short delay parameters and the host model on the SPI pins. */
`timescale 1ns/1ps
module apcs_top_bench;
   import apcs_pkg::*;
   localparam logic [23:0] PWRUP = 24'd20;
   localparam logic [23:0] CAL = 24'd10;
   localparam logic [23:0] PDX = 24'd5;
   localparam logic [14:0] SETUP [3] = '{ADDR_CAL_SETUP_A, ADDR_CAL_SETUP_B, ADDR_CAL_SETUP_C};
   logic clk_in, reset_in, supply_ok, sclk, cs_n, sdi, sdo, sdo_oe, sysref, lmfc, cal_done, pd, slp, reinit;
   apcs_sample_pair_t smp_in, smp_out;
   apcs_link_cfg_t cfg;
   logic [7:0] rdat;
   int mismatches, compares, cycles, reinits;
   apcs_top #(.PWRUP_DELAY_CYC(PWRUP), .CAL_CYC(CAL), .PD_EXIT_CYC(PDX)) dut_u (.clk_in, .reset_in,
      .supply_ok_in(supply_ok), .sysref_in(sysref), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_sdi_in(sdi),
      .samples_in(smp_in), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe), .cal_done_out(cal_done), .power_down_out(pd),
      .sleep_out(slp), .link_reinit_out(reinit), .lmfc_out(lmfc), .samples_out(smp_out), .link_cfg_out(cfg));
   apcs_host_model host_u (.clk_in, .sdo_in(sdo_oe ? sdo : ~sdo), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi));
   // Free-running 100 MHz clock.
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // Cycle ceiling well above the roughly 5300 cycles the cases need, plus a tally of link starts.
   always @(posedge clk_in) begin
      cycles++;
      if (reinit === 1'b1) reinits++;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      host_u.xfer(1'b0, a, d, rdat);
   endtask : wr
   task automatic rd(input logic [14:0] a);
      host_u.xfer(1'b1, a, 8'h00, rdat);
   endtask : rd
   // Bounded wait for the done flag; two more edges let the link start tally land.
   task automatic wait_done(output int n);
      n = 0;
      while (cal_done !== 1'b1 && n < 2000) begin
         @(posedge clk_in);
         n++;
      end
      repeat (2) @(posedge clk_in);
   endtask : wait_done
   // ******************************
   // Scenarios.
   // ******************************
   task automatic t_powerup;
      int n;
      chk("done_early", cal_done, 1'b0);
      @(posedge clk_in) supply_ok <= 1'b1;
      wait_done(n);
      chk("pwrup_min", n >= PWRUP + CAL, 1);
      chk("pwrup_max", n <= PWRUP + CAL + 6, 1);
      chk("first_start", reinits, 1);
      rd(ADDR_LINK_STATUS);
      chk("status", rdat, 8'h01);
      wr(ADDR_LINK_STATUS, 8'hff);
      rd(ADDR_LINK_STATUS);
      chk("status_ro", rdat, 8'h01);
      rd(15'h0005);
      chk("unmapped", rdat, 8'h00);
      chk("subclass1", cfg.subclass1, 1'b1);
   endtask : t_powerup
   // Full host sequence with divider code one, so the divider runs at two meanwhile.
   task automatic t_second;
      int n;
      wr(ADDR_POWER_MODE, 8'h02);
      chk("pd_on", pd, 1'b1);
      chk("pd_done", cal_done, 1'b0);
      wr(ADDR_CLOCK_DIVIDER, 8'h01);
      for (int i = 0; i < 3; i++) wr(SETUP[i], 8'h31 + 8'(i));
      wr(ADDR_POWER_MODE, 8'h00);
      chk("pending", cal_done, 1'b0);
      wait_done(n);
      chk("pdx_min", n >= 2 * (PDX + CAL) - 12, 1);
      chk("pdx_max", n <= 2 * (PDX + CAL) + 6, 1);
      chk("recal_start", reinits, 2);
      wr(ADDR_CLOCK_DIVIDER, 8'h00);
      chk("div_start", reinits, 3);
      for (int i = 0; i < 3; i++) begin
         rd(SETUP[i]);
         chk("setup_kept", rdat, 8'h31 + 8'(i));
      end
   endtask : t_second
   task automatic t_sleep;
      wr(ADDR_POWER_MODE, 8'h01);
      chk("sleep_on", slp, 1'b1);
      wr(ADDR_POWER_MODE, 8'h00);
      repeat (40) @(posedge clk_in);
      chk("wake_done", {slp, cal_done}, 2'b01);
      chk("wake_start", reinits, 3);
      rd(SETUP[0]);
      chk("sleep_kept", rdat, 8'h31);
   endtask : t_sleep
   task automatic t_format;
      chk("twos", smp_out, smp_in);
      wr(ADDR_LINK_FORMAT, 8'h0b);
      repeat (4) @(posedge clk_in);
      chk("offset_bin", smp_out, smp_in ^ 32'h80008000);
      chk("two_lanes", {cfg.two_lanes, cfg.high_density}, 2'b11);
      for (int m = 1; m < 8; m++) begin
         wr(ADDR_LINK_FORMAT, {1'b0, 3'(m), 4'hc});
         chk("test_mode", cfg.test_mode, m % 7);
      end
      chk("scramble", cfg.scramble, 1'b1);
   endtask : t_format
   // K clamps to the one-lane floor, and a single SYSREF edge restarts the multiframe count.
   task automatic t_link;
      wr(ADDR_LINK_FRAMES, 8'h03);
      chk("k_floor", cfg.frames_per_multiframe, K_MIN_ONE_LANE);
      wr(ADDR_LINK_FRAMES, 8'h13);
      @(posedge clk_in) sysref <= 1'b1;
      @(posedge clk_in) sysref <= 1'b0;
      @(posedge clk_in) chk("sysref_lmfc", lmfc, 1'b1);
      repeat (19) @(posedge clk_in);
      chk("lmfc_quiet", lmfc, 1'b0);
      @(posedge clk_in) chk("lmfc_k20", lmfc, 1'b1);
   endtask : t_link
   // Reset for three cycles, then the cases in order.
   initial begin
      reset_in = 1'b1;
      supply_ok = 1'b0;
      sysref = 1'b0;
      smp_in = 32'h12348001;
      repeat (3) @(posedge clk_in);
      reset_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      t_powerup();
      t_second();
      t_sleep();
      t_format();
      t_link();
      give_verdict();
   end
   task automatic give_verdict;
      if (mismatches == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict
endmodule : apcs_top_bench
